/* File: rtl/vid_cfg.svh */
// Constants for the vectored interrupt dispatch block: offsets, fields, reset values, vectors.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
`ifndef VID_CFG_SVH
`define VID_CFG_SVH

// Source count and index order, highest default priority first
`define VID_NSRC        9
`define VID_SRC_LVI     0
`define VID_SRC_TM51    1
`define VID_SRC_KEY     2
`define VID_SRC_RTC     3
`define VID_SRC_PIN6    4
`define VID_SRC_PIN7    5
`define VID_SRC_MULDIV  6
`define VID_SRC_PIN8    7
`define VID_SRC_PIN9    8
`define VID_NPIN        4

// Vector table addresses
`define VID_VEC_RESET   16'h0000
`define VID_VEC_LVI     16'h0004
`define VID_VEC_TM51    16'h002A
`define VID_VEC_KEY     16'h002C
`define VID_VEC_RTC     16'h002E
`define VID_VEC_PIN6    16'h0030
`define VID_VEC_PIN7    16'h0032
`define VID_VEC_MULDIV  16'h0034
`define VID_VEC_PIN8    16'h0038
`define VID_VEC_PIN9    16'h003A
`define VID_VEC_BREAK   16'h003E

// Register byte offsets
`define VID_OFF_REQ     8'h00
`define VID_OFF_MASK    8'h04
`define VID_OFF_PRIO    8'h08
`define VID_OFF_RISE    8'h0C
`define VID_OFF_FALL    8'h10
`define VID_OFF_PSW     8'h14
`define VID_OFF_LVCTL   8'h18
`define VID_OFF_CUR     8'h1C
`define VID_OFF_STAT    8'h20
`define VID_OFF_CLR     8'h24
`define VID_OFF_IEN     8'h28

// Field positions
`define VID_PSW_IE_BIT  0
`define VID_PSW_ISP_BIT 1
`define VID_LV_MODE_BIT 1
`define VID_CUR_VAL_BIT 16
`define VID_CUR_RST_BIT 17
`define VID_EV_ACK      0
`define VID_EV_BREAK    1
`define VID_EV_RESET    2
`define VID_NEV         3

// Reset values
`define VID_RST_REQ     9'h000
`define VID_RST_MASK    9'h1FF
`define VID_RST_PRIO    9'h1FF
`define VID_RST_EDGE    4'h0
`define VID_RST_PSW     2'h2
`define VID_RST_LVCTL   8'h00

`endif

/* File: rtl/vid_pkg.sv */
// Types shared by the vectored interrupt dispatch block.
// Assumes vid_cfg.svh for the widths that these types carry.
`include "vid_cfg.svh"

package vid_pkg;

  // Maskable request lines from peripherals
  typedef struct packed {
    logic                  tm51_compare_match; // Own compare match of timer 51
    logic                  tm51_carrier_mode;  // Timer 51 in carrier generator mode
    logic                  carrier_timer_match;// High-side carrier match strobe
    logic                  key_input_request;  // Key interrupt detection pulse
    logic                  rtc_tick;           // Constant-period pulse
    logic                  rtc_alarm;          // Alarm match pulse
    logic                  muldiv_done;        // Multiply/divide finished pulse
    logic [`VID_NPIN-1:0]  ext_pin;            // Pin levels 6..9
  } vid_src_type;

  // Reset causes
  typedef struct packed {
    logic reset_pin;
    logic power_on_clear;
    logic watchdog_overflow;
    logic low_voltage_detect;
  } vid_rst_src_type;

  // Vector offered to the CPU core
  typedef struct packed {
    logic        valid;    // Vector stands until taken or a reset cause appears
    logic        is_reset; // Reset vector, not an interrupt
    logic [15:0] addr;     // Table address
  } vid_vector_type;

  // Dispatcher states, one-hot
  typedef enum logic [2:0] {
    VID_IDLE  = 3'b001,
    VID_OFFER = 3'b010,
    VID_RESET = 3'b100
  } vid_state_type;

endpackage : vid_pkg

/* File: rtl/vid_edge_detect.sv */
// Edge detection for external pin requests 6..9 with separate rise and fall enables.
// Assumes pin levels are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "vid_cfg.svh"

module vid_edge_detect (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic [`VID_NPIN-1:0] pin_i,
  input  wire logic [`VID_NPIN-1:0] rise_en_i,
  input  wire logic [`VID_NPIN-1:0] fall_en_i,
  output logic      [`VID_NPIN-1:0] event_o
);
  import vid_pkg::*;

  logic [`VID_NPIN-1:0] pin_q;   // Previous pin level

  // Remember last level to find edges
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_i;
    end
  end

  // One detector per pin, each edge gated by its own enable
  for (genvar g = 0; g < `VID_NPIN; g++) begin : g_pin
    assign event_o[g] = (rise_en_i[g] & pin_i[g] & ~pin_q[g])
                      | (fall_en_i[g] & ~pin_i[g] & pin_q[g]);
  end

endmodule : vid_edge_detect
`default_nettype wire

/* File: rtl/vid_prio_pick.sv */
// Fixed-priority pick among eligible maskable sources, high priority group first.
// Assumes index 0 is the highest default priority.
`timescale 1ns/10ps
`default_nettype none
`include "vid_cfg.svh"

module vid_prio_pick (
  input  wire logic [`VID_NSRC-1:0] eligible_i,
  input  wire logic [`VID_NSRC-1:0] prio_i,
  output logic                      found_o,
  output logic [3:0]                index_o
);
  import vid_pkg::*;

  logic [`VID_NSRC-1:0] high_grp; // Eligible sources with priority flag clear
  logic [`VID_NSRC-1:0] pick_set; // Group that wins this cycle

  assign high_grp = eligible_i & ~prio_i;
  assign pick_set = (|high_grp) ? high_grp : eligible_i;
  assign found_o  = |eligible_i;

  // Lowest index wins inside the chosen group
  always_comb begin
    index_o = 4'h0;
    for (int i = `VID_NSRC - 1; i >= 0; i--) begin
      if (pick_set[i]) begin
        index_o = 4'(i);
      end
    end
  end

endmodule : vid_prio_pick
`default_nettype wire

/* File: rtl/vid_top.sv */
// Vectored interrupt dispatch: request flags, masks, priority pick, vectors, resets.
// Assumes an Avalon-MM master on clk_i and a CPU core that takes one vector at a time.
`timescale 1ns/10ps
`default_nettype none
`include "vid_cfg.svh"

module vid_top (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // Avalon-MM slave
  input  wire logic [7:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // Request sources and reset causes
  input  wire vid_pkg::vid_src_type     src_i,
  input  wire vid_pkg::vid_rst_src_type rst_src_i,
  // CPU core side
  input  wire logic                     break_instruction_i,
  input  wire logic                     cpu_take_i,
  output vid_pkg::vid_vector_type       vector_o,
  output logic                          reset_request_o,
  output logic                          irq_o
);
  import vid_pkg::*;

  // Software-visible state
  logic [`VID_NSRC-1:0] req_flag;        // Request flags
  logic [`VID_NSRC-1:0] mask_flag;       // Mask flags, 1 masks
  logic [`VID_NSRC-1:0] priority_flag;   // 0 high group, 1 low group
  logic [`VID_NPIN-1:0] rising_edge_enable;
  logic [`VID_NPIN-1:0] falling_edge_enable;
  logic                 global_enable_flag;
  logic                 in_service_priority; // 1 lets the low group in
  logic [7:0]           lowvolt_control_reg;
  logic [`VID_NEV-1:0]  irq_status;      // Sticky events
  logic [`VID_NEV-1:0]  irq_enable;      // Event enables

  // Dispatch state
  vid_state_type        state;
  logic [3:0]           offer_idx;       // Source being offered
  logic                 offer_is_break;  // Offer is the software interrupt
  logic                 break_pending;   // Break waiting for the dispatcher
  logic                 lv_q;            // Last low-voltage level

  // Bus decode
  logic                 bus_wr;          // Write takes effect this edge
  logic                 bus_rd_start;    // Read captured this edge
  logic [31:0]          next_readdata;

  // Combinational helpers
  logic [`VID_NSRC-1:0] hw_set;          // Hardware request events
  logic [`VID_NPIN-1:0] pin_event;
  logic                 lv_rise;
  logic                 lv_as_reset;
  logic                 any_reset;
  logic [`VID_NSRC-1:0] eligible;
  logic                 pick_found;
  logic [3:0]           pick_idx;
  logic                 taken;           // CPU took the offered vector
  logic [15:0]          next_vec;
  logic [`VID_NEV-1:0]  ev_set;

  // Pin edges
  vid_edge_detect u_edge (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .pin_i     (src_i.ext_pin),
    .rise_en_i (rising_edge_enable),
    .fall_en_i (falling_edge_enable),
    .event_o   (pin_event)
  );

  // Low-voltage detection is a level; only its rise raises an event
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lv_q <= 1'b0;
    end else begin
      lv_q <= rst_src_i.low_voltage_detect;
    end
  end

  assign lv_rise     = rst_src_i.low_voltage_detect & ~lv_q;
  assign lv_as_reset = lowvolt_control_reg[`VID_LV_MODE_BIT];
  assign any_reset   = rst_src_i.reset_pin | rst_src_i.power_on_clear
                     | rst_src_i.watchdog_overflow
                     | (lv_as_reset & rst_src_i.low_voltage_detect);

  // Hardware request events, one per source
  always_comb begin
    hw_set = '0;
    hw_set[`VID_SRC_LVI]    = lv_rise & ~lv_as_reset;
    // Carrier mode swaps the trigger to the carrier match strobe
    hw_set[`VID_SRC_TM51]   = src_i.tm51_carrier_mode ? src_i.carrier_timer_match
                                                      : src_i.tm51_compare_match;
    hw_set[`VID_SRC_KEY]    = src_i.key_input_request;
    hw_set[`VID_SRC_RTC]    = src_i.rtc_tick | src_i.rtc_alarm;
    hw_set[`VID_SRC_PIN6]   = pin_event[0];
    hw_set[`VID_SRC_PIN7]   = pin_event[1];
    hw_set[`VID_SRC_MULDIV] = src_i.muldiv_done;
    hw_set[`VID_SRC_PIN8]   = pin_event[2];
    hw_set[`VID_SRC_PIN9]   = pin_event[3];
  end

  // Only unmasked requests pass, and only with global enable set;
  // while a high-group routine runs, low-group sources wait
  assign eligible = req_flag & ~mask_flag
                  & {`VID_NSRC{global_enable_flag}}
                  & (in_service_priority ? {`VID_NSRC{1'b1}} : ~priority_flag);

  vid_prio_pick u_pick (
    .eligible_i (eligible),
    .prio_i     (priority_flag),
    .found_o    (pick_found),
    .index_o    (pick_idx)
  );

  // Vector table lookup for the picked source
  always_comb begin
    unique case (pick_idx)
      4'h0:    next_vec = `VID_VEC_LVI;
      4'h1:    next_vec = `VID_VEC_TM51;
      4'h2:    next_vec = `VID_VEC_KEY;
      4'h3:    next_vec = `VID_VEC_RTC;
      4'h4:    next_vec = `VID_VEC_PIN6;
      4'h5:    next_vec = `VID_VEC_PIN7;
      4'h6:    next_vec = `VID_VEC_MULDIV;
      4'h7:    next_vec = `VID_VEC_PIN8;
      4'h8:    next_vec = `VID_VEC_PIN9;
      default: next_vec = `VID_VEC_RESET;  // Index above 8 cannot be picked
    endcase
  end

  assign taken = (state == VID_OFFER) & cpu_take_i;

  // Bus handshake: one wait cycle, then the access completes
  assign bus_wr       = avs_write_i & ~avs_waitrequest_o;
  assign bus_rd_start = avs_read_i & avs_waitrequest_o;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  // Read mux; unmapped offsets and the clear register read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address_i)
      `VID_OFF_REQ:   next_readdata[`VID_NSRC-1:0] = req_flag;
      `VID_OFF_MASK:  next_readdata[`VID_NSRC-1:0] = mask_flag;
      `VID_OFF_PRIO:  next_readdata[`VID_NSRC-1:0] = priority_flag;
      `VID_OFF_RISE:  next_readdata[`VID_NPIN-1:0] = rising_edge_enable;
      `VID_OFF_FALL:  next_readdata[`VID_NPIN-1:0] = falling_edge_enable;
      `VID_OFF_PSW: begin
        next_readdata[`VID_PSW_IE_BIT]  = global_enable_flag;
        next_readdata[`VID_PSW_ISP_BIT] = in_service_priority;
      end
      `VID_OFF_LVCTL: next_readdata[7:0] = lowvolt_control_reg;
      `VID_OFF_CUR: begin
        next_readdata[15:0]             = vector_o.addr;
        next_readdata[`VID_CUR_VAL_BIT] = vector_o.valid;
        next_readdata[`VID_CUR_RST_BIT] = reset_request_o;
      end
      `VID_OFF_STAT:  next_readdata[`VID_NEV-1:0] = irq_status;
      `VID_OFF_IEN:   next_readdata[`VID_NEV-1:0] = irq_enable;
      default:        next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is loaded at the edge where waitrequest falls
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_rd_start) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // Request flags: software may write them, hardware sets win over any clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_flag <= `VID_RST_REQ;
    end else begin
      // Software write replaces, acceptance clears, new events set last
      req_flag <= ((bus_wr && avs_address_i == `VID_OFF_REQ) ? avs_writedata_i[`VID_NSRC-1:0]
                                                             : req_flag)
                & ~((taken && !offer_is_break) ? (`VID_NSRC'(1) << offer_idx) : '0)
                | hw_set;
    end
  end

  // Mask, priority and edge enable registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_flag           <= `VID_RST_MASK;
      priority_flag       <= `VID_RST_PRIO;
      rising_edge_enable  <= `VID_RST_EDGE;
      falling_edge_enable <= `VID_RST_EDGE;
      lowvolt_control_reg <= `VID_RST_LVCTL;
      irq_enable          <= '0;
    end else if (bus_wr) begin
      unique case (avs_address_i)
        `VID_OFF_MASK:  mask_flag           <= avs_writedata_i[`VID_NSRC-1:0];
        `VID_OFF_PRIO:  priority_flag       <= avs_writedata_i[`VID_NSRC-1:0];
        `VID_OFF_RISE:  rising_edge_enable  <= avs_writedata_i[`VID_NPIN-1:0];
        `VID_OFF_FALL:  falling_edge_enable <= avs_writedata_i[`VID_NPIN-1:0];
        `VID_OFF_LVCTL: lowvolt_control_reg <= avs_writedata_i[7:0];
        `VID_OFF_IEN:   irq_enable          <= avs_writedata_i[`VID_NEV-1:0];
        default: begin
          // Other offsets handled elsewhere or ignored
        end
      endcase
    end
  end

  // Status-word flags: accepting a maskable request disables further nesting
  // and records the accepted group; software restores them on return
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      global_enable_flag  <= 1'(`VID_RST_PSW >> `VID_PSW_IE_BIT);
      in_service_priority <= 1'b1;
    end else if (taken && !offer_is_break) begin
      global_enable_flag  <= 1'b0;
      in_service_priority <= priority_flag[offer_idx];
    end else if (taken) begin
      global_enable_flag  <= 1'b0; // Break also enters with interrupts off
    end else if (bus_wr && avs_address_i == `VID_OFF_PSW) begin
      global_enable_flag  <= avs_writedata_i[`VID_PSW_IE_BIT];
      in_service_priority <= avs_writedata_i[`VID_PSW_ISP_BIT];
    end
  end

  // Break stays pending until offered; it never looks at masks or enables
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      break_pending <= 1'b0;
    end else if (break_instruction_i) begin
      break_pending <= 1'b1;
    end else if (state == VID_IDLE && !any_reset) begin
      break_pending <= 1'b0;
    end
  end

  // Dispatcher: reset beats break, break beats maskable requests
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state           <= VID_RESET;
      offer_idx       <= 4'h0;
      offer_is_break  <= 1'b0;
      vector_o        <= '{valid: 1'b0, is_reset: 1'b1, addr: `VID_VEC_RESET};
      reset_request_o <= 1'b0;
    end else begin
      reset_request_o <= any_reset;
      unique case (state)
        VID_RESET: begin
          // Restart from the reset vector once every cause has gone
          vector_o <= '{valid: 1'b0, is_reset: 1'b1, addr: `VID_VEC_RESET};
          if (!any_reset) begin
            state <= VID_IDLE;
          end
        end
        VID_IDLE: begin
          if (any_reset) begin
            state <= VID_RESET;
          end else if (break_pending) begin
            state          <= VID_OFFER;
            offer_is_break <= 1'b1;
            vector_o       <= '{valid: 1'b1, is_reset: 1'b0, addr: `VID_VEC_BREAK};
          end else if (pick_found) begin
            state          <= VID_OFFER;
            offer_is_break <= 1'b0;
            offer_idx      <= pick_idx;
            vector_o       <= '{valid: 1'b1, is_reset: 1'b0, addr: next_vec};
          end
        end
        VID_OFFER: begin
          // Vector stands until the core takes it or a reset cause appears
          if (any_reset) begin
            state    <= VID_RESET;
            vector_o <= '{valid: 1'b0, is_reset: 1'b1, addr: `VID_VEC_RESET};
          end else if (cpu_take_i) begin
            state          <= VID_IDLE;
            vector_o.valid <= 1'b0;
          end
        end
        default: begin
          state <= VID_RESET;
        end
      endcase
    end
  end

  // Block events for the interrupt line
  assign ev_set[`VID_EV_ACK]   = taken & ~offer_is_break;
  assign ev_set[`VID_EV_BREAK] = taken & offer_is_break;
  assign ev_set[`VID_EV_RESET] = any_reset & ~reset_request_o;

  // Sticky status; a new event in the clearing cycle stays set
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status
                  & ~((bus_wr && avs_address_i == `VID_OFF_CLR) ? avs_writedata_i[`VID_NEV-1:0] : '0))
                  | ev_set;
    end
  end

  // Level interrupt, registered from the current status and enables
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

endmodule : vid_top
`default_nettype wire

/* File: test/vid_top_assertions.sv */
// Checker for the vectored interrupt dispatch top ports.
// Assumes it is bound to vid_top and that everything runs on clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "vid_cfg.svh"

module vid_top_assertions (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_readdata_o,
  input  wire logic                     avs_waitrequest_o,
  input  wire vid_pkg::vid_rst_src_type rst_src_i,
  input  wire logic                     break_instruction_i,
  input  wire logic                     cpu_take_i,
  input  wire vid_pkg::vid_vector_type  vector_o,
  input  wire logic                     reset_request_o
);
  import vid_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Offer waiting, no reset cause
  sequence s_waiting;
    vector_o.valid && !vector_o.is_reset && !cpu_take_i && !reset_request_o && rst_src_i == '0;
  endsequence
  // Offer taken at this edge
  sequence s_taken;
    vector_o.valid && !vector_o.is_reset && cpu_take_i;
  endsequence

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer after one wait");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_read_hold: assert property (!$past(avs_read_i) |-> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  a_vec_hold: assert property (s_waiting |=> vector_o.valid && $stable(vector_o.addr))
    else $error("vector withdrawn");
  a_take_drop: assert property (s_taken |=> !vector_o.valid)
    else $error("offer stands after take");
  a_break_vector: assert property (break_instruction_i && !vector_o.valid && rst_src_i == '0 && !reset_request_o
    |-> ##[1:12] (vector_o.valid && vector_o.addr == `VID_VEC_BREAK))
    else $error("break vector late");
  a_cause_reset: assert property ((rst_src_i.reset_pin || rst_src_i.power_on_clear || rst_src_i.watchdog_overflow)
    |=> reset_request_o)
    else $error("no reset request");
  a_reset_addr: assert property (vector_o.valid && vector_o.is_reset |-> vector_o.addr == `VID_VEC_RESET)
    else $error("reset vector wrong");
  a_vec_table: assert property (vector_o.valid |-> vector_o.addr inside {`VID_VEC_RESET, `VID_VEC_LVI,
    `VID_VEC_TM51, `VID_VEC_KEY, `VID_VEC_RTC, `VID_VEC_PIN6, `VID_VEC_PIN7, `VID_VEC_MULDIV,
    `VID_VEC_PIN8, `VID_VEC_PIN9, `VID_VEC_BREAK})
    else $error("vector outside table");
endmodule : vid_top_assertions

`default_nettype wire

/* File: test/vid_core_model.sv */
// Core model: takes each offered vector after a set number of cycles.
// Assumes vector_i is registered on clk_i.
`timescale 1ns/10ps
`default_nettype none

module vid_core_model (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire vid_pkg::vid_vector_type vector_i,
  input  wire logic [3:0]              delay_i,
  output logic                         take_o,
  output logic [15:0]                  last_addr_o,
  output logic [7:0]                   taken_o
);
  import vid_pkg::*;
  logic [3:0] wait_cnt; // Cycles the current offer has stood

  // Take after delay_i cycles; a slow core tests the hold
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      take_o      <= 1'b0;
      wait_cnt    <= 4'h0;
      last_addr_o <= 16'h0000;
      taken_o     <= 8'h00;
    end else if (take_o && vector_i.valid) begin // Taken at this edge
      take_o      <= 1'b0;
      wait_cnt    <= 4'h0;
      last_addr_o <= vector_i.addr;
      taken_o     <= taken_o + 8'h01;
    end else if (!vector_i.valid) begin // Nothing offered
      take_o      <= 1'b0;
      wait_cnt    <= 4'h0;
    end else if (wait_cnt >= delay_i) begin
      take_o      <= 1'b1;
    end else begin
      wait_cnt    <= wait_cnt + 4'h1;
    end
  end
endmodule : vid_core_model

`default_nettype wire

/* File: test/vid_top_tb.sv */
// Self-checking bench for the vectored interrupt dispatch block.
// Assumes the package, the checker and the core model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "vid_cfg.svh"

module vid_top_tb;
  import vid_pkg::*;
  logic            clk_i           = 1'b0;
  logic            reset_i         = 1'b1;
  logic [7:0]      avs_address_i   = 8'h00;
  logic            avs_read_i      = 1'b0;
  logic            avs_write_i     = 1'b0;
  logic [31:0]     avs_writedata_i = 32'h0;
  logic [31:0]     avs_readdata_o;
  logic            avs_waitrequest_o;
  vid_src_type     src             = '0; // Bits 10..0: cmp, mode, carrier, key, tick, alarm, muldiv, pins
  vid_rst_src_type rst_src         = '0;
  logic            break_instruction             = 1'b0;
  logic            take;
  vid_vector_type  vector_o;
  logic            reset_request_o;
  logic            irq_o;
  logic [3:0]      delay           = 4'h0;
  logic [15:0]     last_addr;
  logic [7:0]      taken;
  logic [31:0]     rd;
  int              miscompares     = 0;
  int              total_checks    = 0;
  int              cycles          = 0;
  logic [7:0]      offs[5]         = '{`VID_OFF_REQ, `VID_OFF_MASK, `VID_OFF_PRIO, `VID_OFF_PSW, 8'h3C};
  logic [31:0]     rstv[5]         = '{32'h0, 32'h1FF, 32'h1FF, 32'h2, 32'h0};
  logic [15:0]     pinv[4]         = '{`VID_VEC_PIN6, `VID_VEC_PIN7, `VID_VEC_PIN8, `VID_VEC_PIN9};

  always #5 clk_i = ~clk_i;

  vid_top dut_u (.*, .src_i(src), .rst_src_i(rst_src), .break_instruction_i(break_instruction), .cpu_take_i(take));
  vid_core_model core_u (.clk_i(clk_i), .reset_i(reset_i), .vector_i(vector_o), .delay_i(delay),
    .take_o(take), .last_addr_o(last_addr), .taken_o(taken));

  // Verdict and end of run
  task results;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Value comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access, held until the edge that sees waitrequest low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i     <= 1'b0;
    avs_read_i      <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  // Wait for the core to take one vector, then compare its address
  task expect_vec(input logic [15:0] a);
    logic [7:0] t;
    int         n;
    t = taken;
    n = 0;
    while (taken == t && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk({16'h0, last_addr}, {16'h0, a});
  endtask : expect_vec

  // One-cycle source pulse
  task pulse(input vid_src_type p);
    src <= src | p;
    @(posedge clk_i);
    src <= src & ~p;
  endtask : pulse

  // Quiet period with no take
  task no_vec;
    logic [7:0] t;
    t = taken;
    repeat (12) @(posedge clk_i);
    chk({24'h0, taken}, {24'h0, t});
  endtask : no_vec

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, offs[i], 32'h0);
      chk(rd, rstv[i]);
    end
    $display("Test reset values done");
    bus(1'b1, `VID_OFF_MASK, 32'h0);
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    pulse(11'h090); // Key and multiply/divide together
    expect_vec(`VID_VEC_KEY);
    bus(1'b0, `VID_OFF_REQ, 32'h0);
    chk(rd, 32'h40);
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    expect_vec(`VID_VEC_MULDIV);
    bus(1'b1, `VID_OFF_IEN, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, `VID_OFF_IEN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, `VID_OFF_IEN, 32'h1);
    bus(1'b1, `VID_OFF_CLR, 32'h7);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b0, `VID_OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("Test priority and status done");
    bus(1'b1, `VID_OFF_PSW, 32'h1); // High group in service
    pulse(11'h010);
    no_vec();
    bus(1'b1, `VID_OFF_PRIO, 32'h1BF);
    expect_vec(`VID_VEC_MULDIV);
    bus(1'b1, `VID_OFF_PRIO, 32'h1FF);
    bus(1'b1, `VID_OFF_MASK, 32'h8);
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    pulse(11'h020); // Alarm while masked
    no_vec();
    bus(1'b0, `VID_OFF_REQ, 32'h0);
    chk(rd, 32'h8);
    bus(1'b1, `VID_OFF_MASK, 32'h0);
    expect_vec(`VID_VEC_RTC);
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    pulse(11'h040);
    expect_vec(`VID_VEC_RTC);
    delay <= 4'h5; // Slow core, interrupts off
    bus(1'b1, `VID_OFF_PSW, 32'h0);
    break_instruction <= 1'b1;
    @(posedge clk_i);
    break_instruction <= 1'b0;
    expect_vec(`VID_VEC_BREAK);
    delay <= 4'h0;
    $display("Test gating done");
    bus(1'b1, `VID_OFF_RISE, 32'hF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `VID_OFF_PSW, 32'h3);
      src.ext_pin[i] <= 1'b1;
      expect_vec(pinv[i]);
    end
    bus(1'b1, `VID_OFF_RISE, 32'h0);
    bus(1'b1, `VID_OFF_FALL, 32'h8); // Only pin 9 on falling edges
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    src.ext_pin <= 4'h0;
    expect_vec(`VID_VEC_PIN9);
    bus(1'b0, `VID_OFF_REQ, 32'h0);
    chk(rd, 32'h0);
    $display("Test pins done");
    bus(1'b1, `VID_OFF_MASK, 32'h1FF);
    src.tm51_carrier_mode <= 1'b1;
    @(posedge clk_i);
    pulse(11'h400);
    bus(1'b0, `VID_OFF_REQ, 32'h0);
    chk(rd, 32'h0);
    pulse(11'h100);
    bus(1'b0, `VID_OFF_REQ, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, `VID_OFF_REQ, 32'h0);
    bus(1'b1, `VID_OFF_MASK, 32'h0);
    bus(1'b1, `VID_OFF_PSW, 32'h3);
    rst_src.low_voltage_detect <= 1'b1;
    expect_vec(`VID_VEC_LVI);
    chk({31'h0, reset_request_o}, 32'h0);
    rst_src <= '0;
    bus(1'b1, `VID_OFF_LVCTL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      rst_src <= vid_rst_src_type'(4'h1 << i);
      repeat (3) @(posedge clk_i);
      chk({31'h0, reset_request_o}, 32'h1);
      rst_src <= '0;
      repeat (3) @(posedge clk_i);
    end
    $display("Test reset causes done");
    results();
  end
endmodule : vid_top_tb

bind vid_top vid_top_assertions chk_u (.*);

`default_nettype wire
